//--- inc/i2c_sd_pkg.sv
/*
 * package for the serial status, data and hold-time detect block:
 * special function register offsets, status bit positions, reset
 * values, link state codes and the state records of both domains.
 * assumes one host clock domain and one link sample clock domain.
 */
package i2c_sd_pkg;

  // ************************************************************
  // special function register offsets
  // ************************************************************
  localparam logic [7:0] ADDR_DDC_SETUP = 8'hd1;
  localparam logic [7:0] ADDR_MM_SETUP  = 8'hd2;
  localparam logic [7:0] ADDR_STATUS    = 8'hd9;
  localparam logic [7:0] ADDR_DATA      = 8'hda;
  localparam logic [7:0] ADDR_OWN       = 8'hdb;

  // ************************************************************
  // reset values and field positions
  // ************************************************************
  localparam logic [7:0] SETUP_RESET  = 8'h00;
  localparam logic [7:0] OWN_RESET    = 8'h00;
  localparam logic [7:0] DATA_RESET   = 8'h00;
  localparam logic [7:0] UNMAPPED_RD  = 8'h00;
  localparam int         HOLD_EN_BIT  = 7;
  localparam logic [6:0] HOLD_ONE_LIM = 7'h00;
  localparam logic [7:0] GEN_CALL     = 8'h00;
  localparam logic [2:0] LAST_BIT     = 3'h7;
  localparam int         OWN_GC_BIT   = 0;

  localparam int ST_GC    = 7;
  localparam int ST_STOP  = 6;
  localparam int ST_INTERRUPT_FLAG  = 5;
  localparam int ST_TX    = 4;
  localparam int ST_BUSY  = 3;
  localparam int ST_LOST  = 2;
  localparam int ST_NACK  = 1;
  localparam int ST_SLV   = 0;

  // ************************************************************
  // link state machine
  // ************************************************************
  typedef enum logic [6:0] {
    S_IDLE     = 7'h01,
    S_ADDR     = 7'h02,
    S_ADDR_ACK = 7'h04,
    S_RX       = 7'h08,
    S_RX_ACK   = 7'h10,
    S_TX       = 7'h20,
    S_TX_ACK   = 7'h40
  } link_state_t;

  // ************************************************************
  // words crossing between domains
  // ************************************************************
  typedef struct packed {
    logic [7:0] tx_byte;
    logic [7:0] own_addr;
    logic [7:0] hold;
  } cfg_word_t;

  typedef struct packed {
    logic [7:0] rx_byte;
    logic       was_rx;
    logic       gc;
    logic       nack;
    logic       lost;
  } report_t;

  // ************************************************************
  // state records
  // ************************************************************
  typedef struct packed {
    link_state_t st;
    logic        sda_s1;
    logic        sda_s2;
    logic        scl_s1;
    logic        scl_s2;
    logic        scl_p;
    logic        sda_f;
    logic        ack_s1;
    logic        ack_s2;
    logic [6:0]  flt_cnt;
    logic        cfg_t1;
    logic        cfg_t2;
    logic        cfg_t3;
    cfg_word_t   cfg;
    logic [7:0]  shreg;
    logic [2:0]  bitcnt;
    logic        rw;
    logic        gc_hit;
    logic        selected;
    logic        busy;
    logic        lost_acc;
    logic        tx_mode;
    logic        sda_oe;
    logic        sda_out;
    logic        int_tgl;
    logic        stop_tgl;
    report_t     rep;
  } link_t;

  typedef struct packed {
    logic [7:0] ddc_setup;
    logic [7:0] mm_setup;
    logic [7:0] own_addr;
    logic [7:0] data;
    logic       cfg_tgl;
    cfg_word_t  cfg;
    logic       mode_p;
    logic       int_s1;
    logic       int_s2;
    logic       int_s3;
    logic       stop_s1;
    logic       stop_s2;
    logic       stop_s3;
    logic       busy_s1;
    logic       busy_s2;
    logic       busy_p;
    logic       slv_s1;
    logic       slv_s2;
    logic       txm_s1;
    logic       txm_s2;
    logic       gc;
    logic       stop_f;
    logic       interrupt_flag;
    logic       nack;
    logic       lost;
    logic [7:0] rdata;
  } host_t;

  localparam link_t LINK_RESET = '{st: S_IDLE, sda_s1: 1'b1,
                                   sda_s2: 1'b1, scl_s1: 1'b1,
                                   scl_s2: 1'b1, scl_p: 1'b1,
                                   sda_f: 1'b1, default: '0};
  localparam host_t HOST_RESET = '{ddc_setup: SETUP_RESET,
                                   mm_setup: SETUP_RESET,
                                   own_addr: OWN_RESET,
                                   data: DATA_RESET, default: '0};

endpackage

//--- verif/i2c_bus_master_model.sv
/*
 * behavioural bus master on the two-wire bus.
 * assumes a pull-up on sda; scl idles high between frames.
 */
`timescale 1ns/1ps

module i2c_bus_master_model (
  input  wire logic sda_oe,
  input  wire logic sda_out,
  output logic      scl,
  output logic      sda
);
  localparam int Q = 300;
  logic drv;

  // wired-and with pull-up: released line reads high
  assign sda = drv & (~sda_oe | sda_out);

  initial begin
    scl = 1'b1;
    drv = 1'b1;
  end

  // hold_ns: how long sda stays low before scl falls
  task automatic start(input int hold_ns);
    drv = 1'b1;
    #Q;
    drv = 1'b0;
    #(hold_ns);
    scl = 1'b0;
    #Q;
  endtask

  task automatic bit_io(input logic b, output logic s);
    drv = b;
    #Q;
    scl = 1'b1;
    #Q;
    s = sda;
    #Q;
    scl = 1'b0;
    #Q;
  endtask

  task automatic xfer(input logic [7:0] tx, input logic ack_in,
                      output logic [7:0] rx, output logic ack_out);
    for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
    bit_io(ack_in, ack_out);
  endtask

  task automatic stop();
    drv = 1'b0;
    #Q;
    scl = 1'b1;
    #Q;
    drv = 1'b1;
    #Q;
  endtask
endmodule

//--- verif/i2c_sd_sva.sv
/*
 * checker for the serial status, data and hold-time detect block.
 * assumes it is bound to the top module and sees only its ports.
 */
`timescale 1ns/1ps

module i2c_sd_sva
  import i2c_sd_pkg::*;
(
  input wire logic       clk,
  input wire logic       arst_n,
  input wire logic       link_clk,
  input wire logic [7:0] sfr_addr,
  input wire logic       sfr_wr,
  input wire logic       sfr_rd,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic       int_req,
  input wire logic       scl_in,
  input wire logic       sda_out,
  input wire logic       sda_oe
);
  // ************************************************************
  // shadow copies of the two setup registers and the own address register
  // ************************************************************
  logic [7:0] ddc_sh;
  logic [7:0] mm_sh;
  logic [7:0] own_sh;
  logic       mapped;

  assign mapped = sfr_addr inside {ADDR_DDC_SETUP, ADDR_MM_SETUP,
                                   ADDR_STATUS, ADDR_DATA, ADDR_OWN};

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ddc_sh <= SETUP_RESET;
      mm_sh  <= SETUP_RESET;
      own_sh <= OWN_RESET;
    end else if (sfr_wr) begin
      if (sfr_addr == ADDR_DDC_SETUP) ddc_sh <= sfr_wdata;
      if (sfr_addr == ADDR_MM_SETUP) mm_sh <= sfr_wdata;
      if (sfr_addr == ADDR_OWN) own_sh <= sfr_wdata;
    end
  end

  // ************************************************************
  // assertions
  // ************************************************************
  rdata_idle_a: assert property (
    @(posedge clk) disable iff (!arst_n)
    !sfr_rd |=> sfr_rdata == 8'h00) else $error("read data not idle");
  unmapped_rd_a: assert property (
    @(posedge clk) disable iff (!arst_n)
    sfr_rd && !mapped |=> sfr_rdata == UNMAPPED_RD)
    else $error("unmapped read not zero");
  interrupt_flag_clear_a: assert property (
    @(posedge clk) disable iff (!arst_n)
    sfr_rd && sfr_addr == ADDR_STATUS |-> ##[1:3] !int_req)
    else $error("interrupt not cleared by status read");
  ddc_readback_a: assert property (
    @(posedge clk) disable iff (!arst_n)
    sfr_rd && sfr_addr == ADDR_DDC_SETUP |=> sfr_rdata == ddc_sh)
    else $error("ddc hold register mismatch");
  mm_readback_a: assert property (
    @(posedge clk) disable iff (!arst_n)
    sfr_rd && sfr_addr == ADDR_MM_SETUP |=> sfr_rdata == mm_sh)
    else $error("multimaster hold register mismatch");
  own_readback_a: assert property (
    @(posedge clk) disable iff (!arst_n)
    sfr_rd && sfr_addr == ADDR_OWN |=> sfr_rdata == own_sh)
    else $error("own address register mismatch");
  oe_change_a: assert property (
    @(posedge link_clk) disable iff (!arst_n)
    $changed(sda_oe) |-> !scl_in) else $error("sda moved with scl high");
  ack_width_a: assert property (
    @(posedge link_clk) disable iff (!arst_n)
    $rose(sda_oe) |-> sda_oe[*8] ##[1:400] !sda_oe)
    else $error("sda drive width wrong");
  drain_only_a: assert property (
    @(posedge link_clk) disable iff (!arst_n)
    sda_oe |-> sda_out == 1'b0) else $error("sda driven high");

  cover property (@(posedge clk) sfr_rd && sfr_addr == ADDR_STATUS
                  ##1 sfr_rdata[ST_INTERRUPT_FLAG]);
  cover property (@(posedge link_clk) $rose(sda_oe));
  cover property (@(posedge clk) $rose(int_req));
endmodule

bind i2c_status_data_hold_detect i2c_sd_sva u_sva (
  .clk(clk), .arst_n(arst_n), .link_clk(link_clk), .sfr_addr(sfr_addr),
  .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
  .sfr_rdata(sfr_rdata), .int_req(int_req), .scl_in(scl_in),
  .sda_out(sda_out), .sda_oe(sda_oe));

//--- verif/i2c_status_data_hold_detect_tb.sv
/*
 * testbench: register reads and writes plus bus frames from a model.
 * assumes the checker is bound and the master model drives the bus.
 */
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin total_checks++; \
  if ((got) !== (ex)) begin n_fail++; \
  $display("BAD %s exp %h got %h", nm, ex, got); end end

module i2c_status_data_hold_detect_tb;
  import i2c_sd_pkg::*;
  logic       clk, link_clk, arst_n, sfr_wr, sfr_rd, ack_en, mode;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, rd, rx;
  logic       int_req, sda_out, sda_oe, scl, sda, a;
  int         n_fail, total_checks, cycles;
  logic [7:0] map [6] = '{ADDR_DDC_SETUP, ADDR_MM_SETUP, ADDR_STATUS,
                          ADDR_DATA, ADDR_OWN, 8'h55};
  logic       hm [3] = '{1'b1, 1'b0, 1'b0};
  int         hn [3] = '{100, 100, 400};
  logic       ha [3] = '{1'b0, 1'b1, 1'b0};

  i2c_status_data_hold_detect u_i2c_status_data_hold_detect (
    .clk(clk), .arst_n(arst_n), .link_clk(link_clk),
    .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .acknowledge_enable(ack_en), .display_channel_mode(mode),
    .int_req(int_req), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe));
  i2c_bus_master_model u_i2c_bus_master_model (
    .sda_oe(sda_oe), .sda_out(sda_out), .scl(scl), .sda(sda));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // link clock deliberately out of phase with clk
  initial begin
    link_clk = 1'b0;
    #3.3;
    forever #7.5 link_clk = ~link_clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      n_fail++;
      wrap_up();
    end
  end

  // ************************************************************
  // register access and closing
  // ************************************************************
  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    @(negedge clk);
    sfr_addr = ad;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge clk);
    sfr_wr = 1'b0;
    #100;
  endtask
  task automatic rdr(input logic [7:0] ad, output logic [7:0] d);
    @(negedge clk);
    sfr_addr = ad;
    sfr_rd = 1'b1;
    @(negedge clk);
    sfr_rd = 1'b0;
    d = sfr_rdata;
  endtask
  task automatic chk_reg(input logic [7:0] ad, input logic [7:0] ex);
    logic [7:0] d;
    rdr(ad, d);
    `CHK("register", ex, d)
  endtask
  task automatic frame(input logic [7:0] ad, input logic ex_ack);
    u_i2c_bus_master_model.start(400);
    u_i2c_bus_master_model.xfer(ad, 1'b1, rx, a);
    `CHK("address ack", ex_ack, a)
  endtask
  task automatic wrap_up();
    if (n_fail == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    arst_n = 1'b0;
    {sfr_addr, sfr_wdata, sfr_wr, sfr_rd, mode} = '0;
    ack_en = 1'b1;
    repeat (16) @(negedge clk);
    arst_n = 1'b1;
    for (int i = 0; i < 6; i++) chk_reg(map[i], 8'h00);
    wr(ADDR_STATUS, 8'hff);
    wr(8'h55, 8'h77);
    chk_reg(ADDR_STATUS, 8'h00);
    // hold time and address set before slave use
    wr(ADDR_DDC_SETUP, 8'h0b);
    wr(ADDR_MM_SETUP, 8'h8b);
    wr(ADDR_OWN, 8'h84);
    chk_reg(ADDR_DDC_SETUP, 8'h0b);
    chk_reg(ADDR_MM_SETUP, 8'h8b);
    chk_reg(ADDR_OWN, 8'h84);
    for (int i = 0; i < 3; i++) begin
      @(negedge clk);
      mode = hm[i];
      #100;
      u_i2c_bus_master_model.start(hn[i]);
      u_i2c_bus_master_model.xfer(8'h84, 1'b1, rx, a);
      `CHK("hold filter ack", ha[i], a)
      u_i2c_bus_master_model.stop();
      rdr(ADDR_STATUS, rd);
    end
    frame(8'h84, 1'b0);
    `CHK("int pin set", 1'b1, int_req)
    chk_reg(ADDR_STATUS, 8'h21);
    `CHK("int pin clear", 1'b0, int_req)
    chk_reg(ADDR_STATUS, 8'h01);
    u_i2c_bus_master_model.xfer(8'ha5, 1'b1, rx, a);
    chk_reg(ADDR_DATA, 8'ha5);
    chk_reg(ADDR_STATUS, 8'h21);
    u_i2c_bus_master_model.stop();
    chk_reg(ADDR_STATUS, 8'h60);
    chk_reg(ADDR_STATUS, 8'h40);
    wr(ADDR_DATA, 8'h3c);
    frame(8'h85, 1'b0);
    chk_reg(ADDR_STATUS, 8'h31);
    u_i2c_bus_master_model.xfer(8'hff, 1'b1, rx, a);
    `CHK("read byte", 8'h3c, rx)
    rdr(ADDR_STATUS, rd);
    `CHK("nack flag", 8'h02, rd & 8'h02)
    u_i2c_bus_master_model.stop();
    frame(8'h85, 1'b0);
    u_i2c_bus_master_model.xfer(8'h00, 1'b1, rx, a);
    rdr(ADDR_STATUS, rd);
    `CHK("lost flag", 8'h04, rd & 8'h04)
    u_i2c_bus_master_model.stop();
    rdr(ADDR_STATUS, rd);
    frame(8'h90, 1'b1);
    rdr(ADDR_STATUS, rd);
    `CHK("busy other", 8'h08, rd & 8'h09)
    u_i2c_bus_master_model.stop();
    rdr(ADDR_STATUS, rd);
    `CHK("no interrupt", 8'h00, rd & 8'h20)
    wr(ADDR_OWN, 8'h85);
    frame(8'h00, 1'b0);
    rdr(ADDR_STATUS, rd);
    `CHK("general call", 8'h80, rd & 8'h80)
    u_i2c_bus_master_model.stop();
    wr(ADDR_OWN, 8'h84);
    frame(8'h00, 1'b1);
    u_i2c_bus_master_model.stop();
    @(negedge clk);
    ack_en = 1'b0;
    frame(8'h84, 1'b1);
    u_i2c_bus_master_model.stop();
    wrap_up();
  end
endmodule

//--- verilog/i2c_status_data_hold_detect.sv
/*
 * serial status, shift data, own address and start/stop hold-time
 * detection for a two-wire bus slave, with register access on the
 * special function register port.
 * assumes: the link sample clock runs at half the oscillator rate and
 * one tick is one sample; scl/sda are open drain, resolved outside;
 * the control register outside supplies the acknowledge enable.
 */
`timescale 1ns/1ps

module i2c_status_data_hold_detect
  import i2c_sd_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       link_clk,
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic       sfr_rd,
  input  wire logic [7:0] sfr_wdata,
  output logic      [7:0] sfr_rdata,
  input  wire logic       acknowledge_enable,
  input  wire logic       display_channel_mode,
  output logic            int_req,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe
);

  // ************************************************************
  // state records
  // ************************************************************
  link_t lnk_reg;
  link_t lnk_next;
  host_t hst_reg;
  host_t hst_next;

  logic       rise;
  logic       fall;
  logic       start_ev;
  logic       stop_ev;
  logic [6:0] hold_limit;
  logic       addr_match;
  logic       gc_match;
  logic [7:0] in_byte;

  // ************************************************************
  // link domain: filter and byte engine
  // ************************************************************
  always_comb begin
    lnk_next = lnk_reg;
    lnk_next.sda_s1 = sda_in;
    lnk_next.sda_s2 = lnk_reg.sda_s1;
    lnk_next.scl_s1 = scl_in;
    lnk_next.scl_s2 = lnk_reg.scl_s1;
    lnk_next.scl_p  = lnk_reg.scl_s2;
    // ack enable lives on the host clock: two flops before use
    lnk_next.ack_s1 = acknowledge_enable;
    lnk_next.ack_s2 = lnk_reg.ack_s1;
    lnk_next.sda_out = 1'b0;

    // config word is stable once its toggle has crossed
    lnk_next.cfg_t1 = hst_reg.cfg_tgl;
    lnk_next.cfg_t2 = lnk_reg.cfg_t1;
    lnk_next.cfg_t3 = lnk_reg.cfg_t2;
    if (lnk_reg.cfg_t2 != lnk_reg.cfg_t3) begin
      lnk_next.cfg = hst_reg.cfg;
    end

    rise = lnk_reg.scl_s2 & ~lnk_reg.scl_p;
    fall = ~lnk_reg.scl_s2 & lnk_reg.scl_p;
    start_ev = 1'b0;
    stop_ev  = 1'b0;
    in_byte  = {lnk_reg.shreg[6:0], lnk_reg.sda_s2};
    addr_match = (in_byte[7:1] == lnk_reg.cfg.own_addr[7:1]);
    gc_match = (in_byte == GEN_CALL) &
               lnk_reg.cfg.own_addr[OWN_GC_BIT];

    hold_limit = lnk_reg.cfg.hold[HOLD_EN_BIT] ?
                 lnk_reg.cfg.hold[6:0] : HOLD_ONE_LIM;

    if (!lnk_reg.scl_s2) begin
      lnk_next.sda_f   = lnk_reg.sda_s2;
      lnk_next.flt_cnt = 7'h00;
    end else if (lnk_reg.sda_s2 == lnk_reg.sda_f) begin
      lnk_next.flt_cnt = 7'h00;
    end else if (lnk_reg.flt_cnt == hold_limit) begin
      lnk_next.sda_f   = lnk_reg.sda_s2;
      lnk_next.flt_cnt = 7'h00;
      start_ev = ~lnk_reg.sda_s2;
      stop_ev  = lnk_reg.sda_s2;
    end else begin
      lnk_next.flt_cnt = lnk_reg.flt_cnt + 7'h01;
    end

    if (start_ev) begin
      lnk_next.st       = S_ADDR;
      lnk_next.bitcnt   = 3'h0;
      lnk_next.busy     = 1'b1;
      lnk_next.selected = 1'b0;
      lnk_next.lost_acc = 1'b0;
      lnk_next.sda_oe   = 1'b0;
    end else if (stop_ev) begin
      if (lnk_reg.selected) begin
        lnk_next.rep.was_rx = 1'b0;
        lnk_next.int_tgl = ~lnk_reg.int_tgl;
      end
      lnk_next.stop_tgl = ~lnk_reg.stop_tgl;
      lnk_next.st       = S_IDLE;
      lnk_next.busy     = 1'b0;
      lnk_next.selected = 1'b0;
      lnk_next.sda_oe   = 1'b0;
    end else if (rise) begin
      case (lnk_reg.st)
        S_ADDR: begin
          lnk_next.shreg  = in_byte;
          lnk_next.bitcnt = lnk_reg.bitcnt + 3'h1;
          if (lnk_reg.bitcnt == LAST_BIT) begin
            if ((addr_match | gc_match) & lnk_reg.ack_s2) begin
              lnk_next.st       = S_ADDR_ACK;
              lnk_next.selected = 1'b1;
              lnk_next.rw       = lnk_reg.sda_s2 & ~gc_match;
              lnk_next.gc_hit   = gc_match;
              lnk_next.rep = '{rx_byte: in_byte, was_rx: 1'b0,
                               gc: gc_match, nack: 1'b0,
                               lost: 1'b0};
              lnk_next.int_tgl = ~lnk_reg.int_tgl;
            end else begin
              lnk_next.st = S_IDLE;
            end
          end
        end
        S_ADDR_ACK: begin
          lnk_next.bitcnt = 3'h0;
          if (lnk_reg.rw) begin
            lnk_next.st    = S_TX;
            lnk_next.shreg = lnk_reg.cfg.tx_byte;
          end else begin
            lnk_next.st = S_RX;
          end
        end
        S_RX: begin
          lnk_next.shreg  = in_byte;
          lnk_next.bitcnt = lnk_reg.bitcnt + 3'h1;
          if (lnk_reg.bitcnt == LAST_BIT) begin
            lnk_next.st = S_RX_ACK;
            lnk_next.rep = '{rx_byte: in_byte, was_rx: 1'b1,
                             gc: lnk_reg.gc_hit,
                             nack: ~lnk_reg.ack_s2,
                             lost: 1'b0};
            lnk_next.int_tgl = ~lnk_reg.int_tgl;
          end
        end
        S_RX_ACK: begin
          lnk_next.bitcnt = 3'h0;
          lnk_next.st = S_RX;
        end
        S_TX: begin
          if (~lnk_reg.shreg[7] == 1'b0 && !lnk_reg.sda_s2) begin
            lnk_next.lost_acc = 1'b1;
          end
          lnk_next.shreg  = {lnk_reg.shreg[6:0], 1'b0};
          lnk_next.bitcnt = lnk_reg.bitcnt + 3'h1;
          if (lnk_reg.bitcnt == LAST_BIT) begin
            lnk_next.st = S_TX_ACK;
          end
        end
        S_TX_ACK: begin
          lnk_next.rep = '{rx_byte: lnk_reg.shreg, was_rx: 1'b0,
                           gc: lnk_reg.gc_hit,
                           nack: lnk_reg.sda_s2,
                           lost: lnk_reg.lost_acc};
          lnk_next.int_tgl = ~lnk_reg.int_tgl;
          lnk_next.bitcnt  = 3'h0;
          if (lnk_reg.sda_s2) begin
            lnk_next.st = S_IDLE;
          end else begin
            lnk_next.st    = S_TX;
            lnk_next.shreg = lnk_reg.cfg.tx_byte;
          end
        end
        S_IDLE: begin
          lnk_next.st = S_IDLE;
        end
        default: begin
          lnk_next.st = S_IDLE;
        end
      endcase
    end else if (fall) begin
      // data only moves while scl is low, so drive on falls
      lnk_next.sda_oe = (lnk_reg.st == S_ADDR_ACK) |
                        ((lnk_reg.st == S_RX_ACK) & lnk_reg.ack_s2) |
                        ((lnk_reg.st == S_TX) & ~lnk_reg.shreg[7]);
    end

    lnk_next.tx_mode = (lnk_next.st == S_TX) |
                       (lnk_next.st == S_TX_ACK);
  end

  always_ff @(posedge link_clk or negedge arst_n) begin
    if (!arst_n) begin
      lnk_reg <= LINK_RESET;
    end else begin
      lnk_reg <= lnk_next;
    end
  end

  // ************************************************************
  // host domain: registers and status
  // ************************************************************
  logic wr_ddc;
  logic wr_mm;
  logic wr_own;
  logic wr_data;
  logic rd_status;
  logic cfg_chg;

  always_comb begin
    hst_next = hst_reg;
    hst_next.int_s1  = lnk_reg.int_tgl;
    hst_next.int_s2  = hst_reg.int_s1;
    hst_next.int_s3  = hst_reg.int_s2;
    hst_next.stop_s1 = lnk_reg.stop_tgl;
    hst_next.stop_s2 = hst_reg.stop_s1;
    hst_next.stop_s3 = hst_reg.stop_s2;
    hst_next.busy_s1 = lnk_reg.busy;
    hst_next.busy_s2 = hst_reg.busy_s1;
    hst_next.busy_p  = hst_reg.busy_s2;
    hst_next.slv_s1  = lnk_reg.selected;
    hst_next.slv_s2  = hst_reg.slv_s1;
    hst_next.txm_s1  = lnk_reg.tx_mode;
    hst_next.txm_s2  = hst_reg.txm_s1;
    hst_next.mode_p  = display_channel_mode;

    wr_ddc    = sfr_wr & (sfr_addr == ADDR_DDC_SETUP);
    wr_mm     = sfr_wr & (sfr_addr == ADDR_MM_SETUP);
    wr_own    = sfr_wr & (sfr_addr == ADDR_OWN);
    wr_data   = sfr_wr & (sfr_addr == ADDR_DATA);
    rd_status = sfr_rd & (sfr_addr == ADDR_STATUS);

    if (wr_ddc) begin
      hst_next.ddc_setup = sfr_wdata;
    end
    if (wr_mm) begin
      hst_next.mm_setup = sfr_wdata;
    end
    if (wr_own) begin
      hst_next.own_addr = sfr_wdata;
    end
    if (wr_data) begin
      hst_next.data = sfr_wdata;
    end

    cfg_chg = wr_ddc | wr_mm | wr_own | wr_data |
              (display_channel_mode != hst_reg.mode_p);
    if (cfg_chg) begin
      hst_next.cfg_tgl = ~hst_reg.cfg_tgl;
      hst_next.cfg = '{tx_byte: hst_next.data,
                       own_addr: hst_next.own_addr,
                       hold: display_channel_mode ?
                             hst_next.ddc_setup : hst_next.mm_setup};
    end

    if (hst_reg.busy_s2 & ~hst_reg.busy_p) begin
      hst_next.stop_f = 1'b0;
    end
    if (hst_reg.stop_s2 != hst_reg.stop_s3) begin
      hst_next.stop_f = 1'b1;
    end

    if (rd_status) begin
      hst_next.interrupt_flag = 1'b0;
    end
    // report is stable while its toggle crosses
    if (hst_reg.int_s2 != hst_reg.int_s3) begin
      hst_next.interrupt_flag = 1'b1;
      hst_next.gc   = lnk_reg.rep.gc;
      hst_next.nack = lnk_reg.rep.nack;
      hst_next.lost = lnk_reg.rep.lost;
      if (lnk_reg.rep.was_rx) begin
        hst_next.data = lnk_reg.rep.rx_byte;
      end
    end

    hst_next.rdata = UNMAPPED_RD;
    if (sfr_rd) begin
      case (sfr_addr)
        ADDR_DDC_SETUP: hst_next.rdata = hst_reg.ddc_setup;
        ADDR_MM_SETUP:  hst_next.rdata = hst_reg.mm_setup;
        ADDR_OWN:       hst_next.rdata = hst_reg.own_addr;
        ADDR_DATA:      hst_next.rdata = hst_reg.data;
        ADDR_STATUS: begin
          hst_next.rdata[ST_GC]   = hst_reg.gc;
          hst_next.rdata[ST_STOP] = hst_reg.stop_f;
          hst_next.rdata[ST_INTERRUPT_FLAG] = hst_reg.interrupt_flag;
          hst_next.rdata[ST_TX]   = hst_reg.txm_s2;
          hst_next.rdata[ST_BUSY] = hst_reg.busy_s2 & ~hst_reg.slv_s2;
          hst_next.rdata[ST_LOST] = hst_reg.lost;
          hst_next.rdata[ST_NACK] = hst_reg.nack;
          hst_next.rdata[ST_SLV]  = hst_reg.slv_s2;
        end
        default: hst_next.rdata = UNMAPPED_RD;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hst_reg <= HOST_RESET;
    end else begin
      hst_reg <= hst_next;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign sfr_rdata = hst_reg.rdata;
  assign int_req   = hst_reg.interrupt_flag;
  assign sda_out   = lnk_reg.sda_out;
  assign sda_oe    = lnk_reg.sda_oe;

endmodule
